/* common/spa_defines.vh */
// Functional notes
// - parked axis: output stage locked on both channels
// - encoder monitoring off while parked, whatever the parked-safe setting
// - speed, acceleration, position supervision off while parked
// - enter only with safety active and parking
// - reject parked-safe together with braking system
// - acknowledge only when parked-safe bit set
// - single-ack axis drives plain and complement outputs
// - slave also reports over chain bus
// - PLC master: safe only if all present slaves safe
// - door master: also needs dual-channel selector
// - show parked-axis code on display
// - status word shows current safety state
`ifndef SPA_DEFINES_VH
`define SPA_DEFINES_VH

// ack role encodings
`define SPA_ROLE_SINGLE 2'h0
`define SPA_ROLE_SLAVE 2'h1
`define SPA_ROLE_MST_PLC 2'h2
`define SPA_ROLE_MST_DOOR 2'h3

// display codes, two ascii characters
`define SPA_DISP_PARKED 16'h5041
`define SPA_DISP_BLANK 16'h2020

// status word bit positions
`define SPA_ST_SAFETY_ON 0
`define SPA_ST_PARKED 1
`define SPA_ST_LOCKED 2
`define SPA_ST_ACK 3
`define SPA_ST_CFG_ERR 4
`define SPA_ST_LOCK_FLT 5
`define SPA_ST_ACK_FLT 6
`define SPA_ST_W 8

// lock confirmation timeout, in ns, and in cycles at 40 ns
`define SPA_LOCK_TMO_NS 2000
`define SPA_CLK_NS 40
`define SPA_LOCK_TMO_CYC (`SPA_LOCK_TMO_NS / `SPA_CLK_NS)
`define SPA_CNT_W 6
`define SPA_NSLV 4

`endif

/* rtl/spa_ack_mux.v */
`timescale 1ns/1ns
`include "spa_defines.vh"

module spa_ack_mux
(
    input wire [1:0] i_role, // acknowledgment role
    input wire i_safe, // axis itself in safe parked state
    input wire [`SPA_NSLV-1:0] i_slave_safe, // per slave safe report
    input wire [`SPA_NSLV-1:0] i_slave_present, // slave is configured
    input wire i_sel_ch1, // mode selector channel 1
    input wire i_sel_ch2, // mode selector channel 2
    output reg o_ack // resulting safety acknowledgment
);

    wire all_slaves;

    // absent slaves do not hold the master off
    assign all_slaves = &(i_slave_safe | ~i_slave_present);

    // role based combination of own and slave safety
    always @*
    begin
        case (i_role)
            `SPA_ROLE_SINGLE: o_ack = i_safe;
            `SPA_ROLE_SLAVE: o_ack = i_safe;
            `SPA_ROLE_MST_PLC: o_ack = i_safe & all_slaves;
            `SPA_ROLE_MST_DOOR:
                o_ack = i_safe & all_slaves & i_sel_ch1 & i_sel_ch2;
            default: o_ack = 1'b0;
        endcase
    end

endmodule

/* rtl/spa_parked_axis.v */
`timescale 1ns/1ns
`include "spa_defines.vh"

module spa_parked_axis
(
    input wire i_core_clk, // core clock, 25 MHz
    input wire i_rstn, // async reset, active low
    input wire i_safety_active, // safety technology activated
    input wire i_park_select, // drive parking function selected
    input wire i_cfg_parked_safe, // parked axis declared safe
    input wire i_cfg_brake_hold, // braking and holding system set
    input wire [1:0] i_cfg_role, // acknowledgment role
    input wire i_lock_conf_ch1, // channel 1 lock confirmed
    input wire i_lock_conf_ch2, // channel 2 lock confirmed
    input wire [`SPA_NSLV-1:0] i_slave_safe, // slave safe reports
    input wire [`SPA_NSLV-1:0] i_slave_present, // slaves configured
    input wire i_sel_ch1, // mode selector channel 1
    input wire i_sel_ch2, // mode selector channel 2
    input wire i_diag_out_rb, // plain output read back
    input wire i_diag_cmp_rb, // complement output read back
    input wire i_fault_clear, // clear latched faults
    output reg o_lock_ch1, // output stage lock channel 1
    output reg o_lock_ch2, // output stage lock channel 2
    output reg o_enc_mon_en, // encoder monitoring enable
    output reg o_motion_mon_en, // speed/accel/position enable
    output reg o_diag_output_plain, // diagnostic output, high = safe
    output reg o_diag_output_complement, // complement, low = safe
    output reg o_diag_chain_bus, // safe report to chain master
    output reg [15:0] o_display, // front-panel characters
    output reg [`SPA_ST_W-1:0] o_status, // safety operating status
    output reg o_cfg_error, // configuration rejected
    output reg o_output_stage_interlock_fault, // lock not confirmed
    output reg o_ack_signal_check_fault // ack read back mismatch
);

    // ************************************************************
    // state
    // ************************************************************
    localparam ST_RUN = 3'b001;
    localparam ST_LOCKING = 3'b010;
    localparam ST_PARKED = 3'b100;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [`SPA_CNT_W-1:0] tmo_reg;
    reg [`SPA_CNT_W-1:0] tmo_next;
    reg lock_flt_reg;
    reg ack_flt_reg;
    reg ack_prev_reg;
    wire cfg_bad;
    wire want_park;
    wire confirmed;
    wire own_safe;
    wire mux_ack;
    wire locking;

    // parked-safe and braking system are mutually exclusive
    assign cfg_bad = i_cfg_parked_safe & i_cfg_brake_hold;
    assign want_park = i_safety_active & i_park_select;
    assign confirmed = i_lock_conf_ch1 & i_lock_conf_ch2;
    assign locking = state_reg != ST_RUN;
    assign own_safe = (state_reg == ST_PARKED) & i_cfg_parked_safe
        & ~cfg_bad & ~lock_flt_reg;

    // role dependent acknowledgment
    spa_ack_mux u_ack_mux
    (
        .i_role(i_cfg_role),
        .i_safe(own_safe),
        .i_slave_safe(i_slave_safe),
        .i_slave_present(i_slave_present),
        .i_sel_ch1(i_sel_ch1),
        .i_sel_ch2(i_sel_ch2),
        .o_ack(mux_ack)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always @*
    begin
        state_next = state_reg;
        tmo_next = tmo_reg;
        case (state_reg)
            ST_RUN:
            begin
                tmo_next = {`SPA_CNT_W{1'b0}};
                if (want_park)
                    state_next = ST_LOCKING;
            end
            ST_LOCKING:
            begin
                if (!want_park)
                    state_next = ST_RUN;
                else if (confirmed)
                    state_next = ST_PARKED;
                else if (tmo_reg != `SPA_LOCK_TMO_CYC)
                    tmo_next = tmo_reg + 1'b1;
            end
            ST_PARKED:
            begin
                if (!want_park)
                    state_next = ST_RUN;
            end
            default: state_next = ST_RUN;
        endcase
    end

    // state registers
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg <= ST_RUN;
            tmo_reg <= {`SPA_CNT_W{1'b0}};
        end
        else
        begin
            state_reg <= state_next;
            tmo_reg <= tmo_next;
        end
    end

    // ************************************************************
    // faults
    // ************************************************************
    // sticky faults, a new fault beats a clear in the same cycle
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            lock_flt_reg <= 1'b0;
            ack_flt_reg <= 1'b0;
            ack_prev_reg <= 1'b0;
        end
        else
        begin
            ack_prev_reg <= o_diag_output_plain;
            // confirmation missing at timeout or lost while parked
            if ((state_reg == ST_LOCKING && !confirmed
                    && tmo_reg == `SPA_LOCK_TMO_CYC)
                || (state_reg == ST_PARKED && !confirmed))
                lock_flt_reg <= 1'b1;
            else if (i_fault_clear)
                lock_flt_reg <= 1'b0;
            // outputs must read back as a stable complementary pair
            if (ack_prev_reg == o_diag_output_plain
                && (i_diag_out_rb != o_diag_output_plain
                    || i_diag_cmp_rb != o_diag_output_complement))
                ack_flt_reg <= 1'b1;
            else if (i_fault_clear)
                ack_flt_reg <= 1'b0;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_lock_ch1 <= 1'b0;
            o_lock_ch2 <= 1'b0;
            o_enc_mon_en <= 1'b1;
            o_motion_mon_en <= 1'b1;
            o_diag_output_plain <= 1'b0;
            o_diag_output_complement <= 1'b1;
            o_diag_chain_bus <= 1'b0;
            o_display <= `SPA_DISP_BLANK;
            o_status <= {`SPA_ST_W{1'b0}};
            o_cfg_error <= 1'b0;
            o_output_stage_interlock_fault <= 1'b0;
            o_ack_signal_check_fault <= 1'b0;
        end
        else
        begin
            // lock held on both channels while parking
            o_lock_ch1 <= (state_next != ST_RUN);
            o_lock_ch2 <= (state_next != ST_RUN);
            o_enc_mon_en <= (state_next == ST_RUN);
            o_motion_mon_en <= (state_next == ST_RUN);
            o_diag_output_plain <= mux_ack;
            o_diag_output_complement <= ~mux_ack;
            o_diag_chain_bus <= (i_cfg_role == `SPA_ROLE_SLAVE)
                & mux_ack;
            o_display <= (state_reg == ST_PARKED) ?
                `SPA_DISP_PARKED : `SPA_DISP_BLANK;
            o_cfg_error <= cfg_bad;
            o_output_stage_interlock_fault <= lock_flt_reg;
            o_ack_signal_check_fault <= ack_flt_reg;
            // status word snapshot
            o_status <= {{(`SPA_ST_W-7){1'b0}}, ack_flt_reg, lock_flt_reg,
                cfg_bad, mux_ack, locking,
                state_reg == ST_PARKED, i_safety_active};
        end
    end

endmodule

/* tb/spa_park_chk_properties.sv */
`timescale 1ns/1ns
`include "spa_defines.vh"
// ****************************
// parked axis checks
// ****************************
module spa_park_chk
(
    input wire i_core_clk, // clock
    input wire i_rstn, // reset, low
    input wire i_safety_active, // safety on
    input wire i_park_select, // parking
    input wire i_cfg_parked_safe, // parked safe
    input wire i_cfg_brake_hold, // brake system
    input wire o_lock_ch1, // lock 1
    input wire o_lock_ch2, // lock 2
    input wire o_enc_mon_en, // encoder mon
    input wire o_motion_mon_en, // motion mon
    input wire o_diag_output_plain, // ack
    input wire o_diag_output_complement, // ack inverse
    input wire [15:0] o_display, // display
    input wire o_cfg_error // cfg reject
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);
    // park request and locked stage
    sequence s_want;
        i_safety_active && i_park_select;
    endsequence
    sequence s_locked;
        o_lock_ch1 && o_lock_ch2;
    endsequence
    chk_lock_both: assert property (s_want |=> s_locked)
        else $error("stage not locked on both channels");
    chk_enc_off: assert property (s_want |=> !o_enc_mon_en)
        else $error("encoder monitoring left on");
    chk_motion_off: assert property (s_want |=> !o_motion_mon_en)
        else $error("motion supervision left on");
    chk_lock_cause: assert property ($rose(o_lock_ch1) |->
        $past(i_safety_active && i_park_select))
        else $error("lock without safety and parking");
    chk_cfg_reject: assert property (1'b1 |=> o_cfg_error ==
        $past(i_cfg_parked_safe && i_cfg_brake_hold))
        else $error("config error wrong");
    chk_ack_gate: assert property ($rose(o_diag_output_plain) |->
        $past(i_cfg_parked_safe) && !o_cfg_error)
        else $error("ack without parked safe config");
    chk_pair_inv: assert property (o_diag_output_plain
        ^ o_diag_output_complement)
        else $error("diag outputs not inverse");
    chk_disp_code: assert property (o_diag_output_plain |->
        o_display == `SPA_DISP_PARKED)
        else $error("ack without parked display code");
endmodule
bind spa_parked_axis spa_park_chk u_chk
(
    .i_core_clk, .i_rstn, .i_safety_active, .i_park_select,
    .i_cfg_parked_safe, .i_cfg_brake_hold, .o_lock_ch1, .o_lock_ch2,
    .o_enc_mon_en, .o_motion_mon_en, .o_diag_output_plain,
    .o_diag_output_complement, .o_display, .o_cfg_error
);

/* tb/spa_tb_stage.sv */
`timescale 1ns/1ns
// ****************************
// output stage and read back model
// ****************************
module spa_tb_stage
(
    input wire i_clk, // core clock
    input wire i_hold, // withhold channel 1 confirm
    input wire i_lock_ch1, // lock request 1
    input wire i_lock_ch2, // lock request 2
    input wire i_plain, // diag plain
    input wire i_comp, // diag complement
    input wire i_flip, // corrupt plain read back
    output reg o_conf_ch1, // confirmation 1
    output reg o_conf_ch2, // confirmation 2
    output wire o_plain_rb, // read back plain
    output wire o_comp_rb // read back complement
);
    // stage confirms one cycle after lock
    initial
    begin
        o_conf_ch1 = 1'b0;
        o_conf_ch2 = 1'b0;
    end
    always @(posedge i_clk)
    begin
        o_conf_ch1 <= i_lock_ch1 & ~i_hold;
        o_conf_ch2 <= i_lock_ch2;
    end
    // complement read straight back, plain xored with i_flip
    assign o_plain_rb = i_plain ^ i_flip;
    assign o_comp_rb = i_comp;
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ns
`include "spa_defines.vh"
module tb_top;
    reg clk, rstn, sa, ps, cps, cbh, sel1, sel2, clr, hold, flip;
    reg [1:0] role;
    reg [3:0] slv, pres;
    wire l1, l2, c1, c2, enc, mot, pl, cp, prb, crb, chn, cfe, lf, af;
    wire [15:0] disp;
    wire [7:0] st;
    integer bad_count, checks_done;
    spa_parked_axis u_dut (.i_core_clk(clk), .i_rstn(rstn),
        .i_safety_active(sa), .i_park_select(ps), .i_cfg_parked_safe(cps),
        .i_cfg_brake_hold(cbh), .i_cfg_role(role), .i_lock_conf_ch1(c1),
        .i_lock_conf_ch2(c2), .i_slave_safe(slv), .i_slave_present(pres),
        .i_sel_ch1(sel1), .i_sel_ch2(sel2), .i_diag_out_rb(prb),
        .i_diag_cmp_rb(crb), .i_fault_clear(clr), .o_lock_ch1(l1),
        .o_lock_ch2(l2), .o_enc_mon_en(enc), .o_motion_mon_en(mot),
        .o_diag_output_plain(pl), .o_diag_output_complement(cp),
        .o_diag_chain_bus(chn), .o_display(disp), .o_status(st),
        .o_cfg_error(cfe), .o_output_stage_interlock_fault(lf),
        .o_ack_signal_check_fault(af));
    spa_tb_stage u_stage (.i_clk(clk), .i_hold(hold), .i_lock_ch1(l1),
        .i_lock_ch2(l2), .i_plain(pl), .i_comp(cp), .i_flip(flip),
        .o_conf_ch1(c1),
        .o_conf_ch2(c2), .o_plain_rb(prb), .o_comp_rb(crb));
    always #20 clk = ~clk;
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        if (got !== exp)
            bad_count = bad_count + 1;
    end
    endtask
    task wait_disp(input [15:0] v);
        integer n;
    begin
        n = 0;
        while (disp !== v && n < 80)
        begin
            @(negedge clk);
            n = n + 1;
        end
        if (disp !== v)
        begin
            chk(disp, v);
            end_sim;
        end
    end
    endtask
    // park, compare outputs, unpark
    task park(input [1:0] r, input p, input b, input [3:0] s, input e,
        input a);
    begin
        {role, cps, cbh, slv, sel2, sa, ps} = {r, p, b, s, e, 2'b11};
        wait_disp(`SPA_DISP_PARKED);
        @(negedge clk);
        chk({l1, l2, enc, mot}, 4'hC);
        chk({pl, cp}, {a, !a});
        chk(chn, a && r == `SPA_ROLE_SLAVE);
        chk(st[`SPA_ST_ACK], a);
        chk(cfe, p && b);
        ps = 1'b0;
        wait_disp(`SPA_DISP_BLANK);
        chk({l1, l2, enc, mot, pl}, 5'h06);
        $display("test done role %0d ack %0d", r, a);
    end
    endtask
    initial
    begin
        {clk, rstn, sa, ps, cps, cbh, role, slv, sel2, clr, hold, flip} = 0;
        {sel1, pres} = 5'h1F;
        bad_count = 0;
        checks_done = 0;
        repeat (20) @(negedge clk);
        chk({st, l1, cp}, 10'h001);
        rstn = 1'b1;
        @(negedge clk);
        park(`SPA_ROLE_SINGLE, 1, 0, 4'hF, 0, 1);
        park(`SPA_ROLE_SLAVE, 1, 0, 4'hF, 0, 1);
        park(`SPA_ROLE_SINGLE, 0, 0, 4'hF, 0, 0);
        park(`SPA_ROLE_SINGLE, 1, 1, 4'hF, 0, 0);
        park(`SPA_ROLE_MST_PLC, 1, 0, 4'h7, 0, 0);
        park(`SPA_ROLE_MST_PLC, 1, 0, 4'hF, 0, 1);
        park(`SPA_ROLE_MST_DOOR, 1, 0, 4'hF, 0, 0);
        park(`SPA_ROLE_MST_DOOR, 1, 0, 4'hF, 1, 1);
        sel1 = 1'b0;
        park(`SPA_ROLE_MST_DOOR, 1, 0, 4'hF, 1, 0);
        {sel1, pres} = 5'h17;
        park(`SPA_ROLE_MST_PLC, 1, 0, 4'h7, 0, 1);
        pres = 4'hF;
        {sa, ps} = 2'b01;
        repeat (5) @(negedge clk);
        chk({l1, l2}, 2'b00);
        chk(disp, `SPA_DISP_BLANK);
        $display("test done no safety");
        {sa, hold} = 2'b11;
        repeat (60) @(negedge clk);
        chk({lf, pl}, 2'b10);
        chk(disp, `SPA_DISP_BLANK);
        chk(st[`SPA_ST_LOCK_FLT], 1);
        {ps, hold, clr} = 3'b001;
        repeat (3) @(negedge clk);
        chk(lf, 0);
        $display("test done lock fault");
        // confirmation lost while parked, clear held high
        {role, ps} = {`SPA_ROLE_SINGLE, 1'b1};
        wait_disp(`SPA_DISP_PARKED);
        hold = 1'b1;
        repeat (4) @(negedge clk);
        chk({lf, pl, cp}, 3'h5);
        {ps, hold} = 2'b00;
        wait_disp(`SPA_DISP_BLANK);
        repeat (2) @(negedge clk);
        chk(lf, 0);
        $display("test done lock lost");
        // corrupted read back of the plain output
        flip = 1'b1;
        repeat (3) @(negedge clk);
        chk({af, st[`SPA_ST_ACK_FLT]}, 2'b11);
        flip = 1'b0;
        repeat (3) @(negedge clk);
        chk(af, 0);
        $display("test done read back");
        end_sim;
    end
endmodule
